/* File: core/output_power_sync_detect.sv */
// Output power-down, clock-loss sleep and sync-activity detect with APB registers
//
// The implementer's own choices: the register offsets and the APB slave port.
module output_power_sync_detect
  import power_sync_pkg::*;
#(
  parameter int data_w     = 24,
  parameter int de_timeout = de_timeout_cycles
) (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              chip_sleep_n,
  input  wire logic              output_float_n,
  input  wire logic              video_clk_in,
  input  wire logic              de_in,
  input  wire logic [data_w-1:0] pixel_in,
  input  wire logic              pixel_clk_in,
  input  wire logic              general_control_out_1_in,
  input  wire logic              general_control_out_2_in,
  input  wire logic              general_control_out_3_in,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  output logic                   sync_activity_flag,
  output logic                   general_control_out_1,
  output logic [data_w-1:0]      pixel_out,
  output logic [data_w-1:0]      pixel_out_oe,
  output logic                   pixel_out_clock,
  output logic                   pixel_out_clock_oe,
  output logic                   de_out,
  output logic                   de_out_oe,
  output logic                   general_control_out_2,
  output logic                   general_control_out_2_oe,
  output logic                   general_control_out_3,
  output logic                   general_control_out_3_oe
);
  localparam int tout_w = 24;

  initial begin
    if (data_w < 1 || data_w > 32) $error("output_power_sync_detect: data_w out of range");
    if (de_timeout < 1 || de_timeout >= (1 << tout_w)) $error("output_power_sync_detect: bad timeout");
  end

  // Pin synchronisers
  logic [1:0]        sleep_sync_reg;
  logic [1:0]        float_sync_reg;
  logic [1:0]        ctl_sync1_reg;
  logic [1:0]        ctl_sync2_reg;
  logic [1:0]        ctl_sync3_reg;
  logic [1:0]        pclk_sync_reg;
  logic [data_w-1:0] pix_sync1_reg;
  logic [data_w-1:0] pix_sync2_reg;
  logic [1:0]        de_sync_reg;

  // Registers
  logic [1:0]        ctrl_reg;
  logic [3:0]        irq_stat_reg;
  logic [3:0]        irq_mask_reg;
  logic [tout_w-1:0] de_cnt_reg;
  logic              de_last_reg;
  logic              de_active_reg;
  logic              de_active_last_reg;
  logic              clk_ok_last_reg;
  logic              clk_ok;
  logic              awake;
  logic              drive_en;
  logic              apb_write;
  logic              apb_read;
  logic [3:0]        irq_events;

  // Every pin except the APB bus crosses two flip-flops before any logic reads it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sleep_sync_reg <= 2'h0;
      float_sync_reg <= 2'h3;
      ctl_sync1_reg  <= 2'h0;
      ctl_sync2_reg  <= 2'h0;
      ctl_sync3_reg  <= 2'h0;
      pclk_sync_reg  <= 2'h0;
      de_sync_reg    <= 2'h0;
      pix_sync1_reg  <= '0;
      pix_sync2_reg  <= '0;
    end else begin
      sleep_sync_reg <= {sleep_sync_reg[0], chip_sleep_n};
      float_sync_reg <= {float_sync_reg[0], output_float_n};
      ctl_sync1_reg  <= {ctl_sync1_reg[0], general_control_out_1_in};
      ctl_sync2_reg  <= {ctl_sync2_reg[0], general_control_out_2_in};
      ctl_sync3_reg  <= {ctl_sync3_reg[0], general_control_out_3_in};
      pclk_sync_reg  <= {pclk_sync_reg[0], pixel_clk_in};
      de_sync_reg    <= {de_sync_reg[0], de_in};
      pix_sync1_reg  <= pixel_in;
      pix_sync2_reg  <= pix_sync1_reg;
    end
  end

  // Video clock detector keeps running even while the chip sleeps
  activity_watch #(
    .timeout (clk_timeout_cycles),
    .cnt_w   (clk_cnt_w)
  ) u_clk_watch (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .enable    (1'b1),
    .sig_async (video_clk_in),
    .active    (clk_ok)
  );

  // Internal logic runs only with the sleep pin high, software awake and a live clock
  assign awake = sleep_sync_reg[1] & ~ctrl_reg[ctrl_sleep_bit] & clk_ok;
  // Floated outputs: sleep or output float; reset of float sync is high so an open pin drives
  assign drive_en = awake & float_sync_reg[1] & ~ctrl_reg[ctrl_float_bit];

  // Data-enable inactivity window, restarted by every transition
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      de_cnt_reg    <= '0;
      de_last_reg   <= 1'b0;
      de_active_reg <= 1'b0;
    end else if (!awake) begin
      de_cnt_reg    <= '0;
      de_last_reg   <= de_sync_reg[1];
      de_active_reg <= 1'b0;
    end else begin
      de_last_reg <= de_sync_reg[1];
      if (de_sync_reg[1] != de_last_reg) begin
        de_cnt_reg    <= '0;
        de_active_reg <= 1'b1;
      end else if (de_cnt_reg < tout_w'(de_timeout - 1)) begin
        de_cnt_reg <= de_cnt_reg + 1'b1;
      end else begin
        de_active_reg <= 1'b0;
      end
    end
  end

  // Always-driven outputs, never floated
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync_activity_flag    <= 1'b0;
      general_control_out_1 <= 1'b0;
    end else begin
      sync_activity_flag    <= de_active_reg;
      general_control_out_1 <= awake & ctl_sync1_reg[1];
    end
  end

  // Floatable outputs: value forced low and enable dropped, the pad pull-down shows low
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pixel_out                <= '0;
      pixel_out_oe             <= '0;
      pixel_out_clock          <= 1'b0;
      pixel_out_clock_oe       <= 1'b0;
      de_out                   <= 1'b0;
      de_out_oe                <= 1'b0;
      general_control_out_2    <= 1'b0;
      general_control_out_2_oe <= 1'b0;
      general_control_out_3    <= 1'b0;
      general_control_out_3_oe <= 1'b0;
    end else begin
      pixel_out                <= drive_en ? pix_sync2_reg : '0;
      pixel_out_oe             <= {data_w{drive_en}};
      pixel_out_clock          <= drive_en & pclk_sync_reg[1];
      pixel_out_clock_oe       <= drive_en;
      de_out                   <= drive_en & de_sync_reg[1];
      de_out_oe                <= drive_en;
      general_control_out_2    <= drive_en & ctl_sync2_reg[1];
      general_control_out_2_oe <= drive_en;
      general_control_out_3    <= drive_en & ctl_sync3_reg[1];
      general_control_out_3_oe <= drive_en;
    end
  end

  // APB decode; zero wait states
  assign apb_write = psel & penable & pwrite;
  assign apb_read  = psel & ~penable & ~pwrite;

  // Control and mask registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg     <= ctrl_reset;
      irq_mask_reg <= mask_reset;
    end else if (apb_write) begin
      if (paddr == ctrl_off) ctrl_reg <= pwdata[1:0];
      if (paddr == mask_off) irq_mask_reg <= pwdata[3:0];
    end
  end

  // Edge history for events
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      de_active_last_reg <= 1'b0;
      clk_ok_last_reg    <= 1'b0;
    end else begin
      de_active_last_reg <= de_active_reg;
      clk_ok_last_reg    <= clk_ok;
    end
  end

  assign irq_events = {~clk_ok & clk_ok_last_reg, clk_ok & ~clk_ok_last_reg,
                       ~de_active_reg & de_active_last_reg, de_active_reg & ~de_active_last_reg};

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_reg <= 4'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((apb_write && paddr == irq_off) ? pwdata[3:0] : 4'h0)) | irq_events;
    end
  end

  // Level interrupt output
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read data is captured in setup so it stands through the access phase
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~(paddr == ctrl_off || paddr == status_off || paddr == irq_off ||
                                     paddr == mask_off || paddr == tout_off);
      if (apb_read) begin
        case (paddr)
          ctrl_off:   prdata <= {30'h0, ctrl_reg};
          status_off: prdata <= {27'h0, drive_en, awake, clk_ok, float_sync_reg[1], de_active_reg};
          irq_off:    prdata <= {28'h0, irq_stat_reg};
          mask_off:   prdata <= {28'h0, irq_mask_reg};
          tout_off:   prdata <= 32'(de_timeout);
          default:    prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule

/* File: core/power_sync_pkg.sv */
// Shared constants for the output power and sync-detect block
package power_sync_pkg;
  // APB register byte offsets
  localparam logic [7:0] ctrl_off   = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] irq_off    = 8'h08;
  localparam logic [7:0] mask_off   = 8'h0c;
  localparam logic [7:0] tout_off   = 8'h10;
  // Control register fields
  localparam int ctrl_float_bit = 0;
  localparam int ctrl_sleep_bit = 1;
  localparam logic [1:0] ctrl_reset = 2'h0;
  // Interrupt status fields
  localparam int irq_rise_bit   = 0;
  localparam int irq_fall_bit   = 1;
  localparam int irq_clkok_bit  = 2;
  localparam int irq_clklos_bit = 3;
  localparam logic [3:0] mask_reset = 4'h0;
  // Data-enable inactivity window
  localparam int de_timeout_ns     = 100000;
  localparam int core_clk_ns       = 100;
  localparam int de_timeout_cycles = de_timeout_ns / core_clk_ns;
  // Video clock loss window, in core cycles
  localparam int clk_timeout_cycles = 16;
  localparam int clk_cnt_w = 8;
endpackage

/* File: core/activity_watch.sv */
// Toggle watchdog: flags activity while a synchronised input keeps changing
module activity_watch
  import power_sync_pkg::*;
#(
  parameter int timeout = 16,
  parameter int cnt_w   = 8
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic enable,
  input  wire logic sig_async,
  output logic      active
);
  logic [1:0]       sync_reg;
  logic             last_reg;
  logic [cnt_w-1:0] cnt_reg;
  logic             edge_seen;

  initial begin
    if (timeout < 1 || timeout >= (1 << cnt_w)) $error("activity_watch: timeout does not fit counter");
  end

  // Two-stage synchroniser; only the second stage is read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync_reg <= 2'h0;
      last_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[0], sig_async};
      last_reg <= sync_reg[1];
    end
  end

  assign edge_seen = sync_reg[1] ^ last_reg;

  // Idle counter: restarts on each transition, saturates at the window
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= cnt_w'(timeout);
      active  <= 1'b0;
    end else if (!enable) begin
      cnt_reg <= cnt_w'(timeout);
      active  <= 1'b0;
    end else if (edge_seen) begin
      cnt_reg <= '0;
      active  <= 1'b1;
    end else if (cnt_reg < cnt_w'(timeout - 1)) begin
      cnt_reg <= cnt_reg + 1'b1;
    end else begin
      cnt_reg <= cnt_w'(timeout);
      active  <= 1'b0;
    end
  end
endmodule

/* File: test/output_power_sync_detect_chk.sv */
// Concurrent checks on the output power and sync-detect block
module output_power_sync_detect_chk
  import power_sync_pkg::*;
#(
  parameter int data_w     = 24,
  parameter int de_timeout = de_timeout_cycles
) (
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire logic              chip_sleep_n,
  input wire logic              output_float_n,
  input wire logic              video_clk_in,
  input wire logic              de_in,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              sync_activity_flag,
  input wire logic [data_w-1:0] pixel_out,
  input wire logic [data_w-1:0] pixel_out_oe,
  input wire logic              pixel_out_clock_oe,
  input wire logic              de_out,
  input wire logic              de_out_oe,
  input wire logic              general_control_out_2_oe,
  input wire logic              general_control_out_3_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  logic de_q;
  logic vclk_q;
  int   de_idle;
  int   vclk_idle;
  // Cycles since the last edge of data enable and of the video clock
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      de_q      <= 1'b0;
      vclk_q    <= 1'b0;
      de_idle   <= 0;
      vclk_idle <= 0;
    end else begin
      de_q      <= de_in;
      vclk_q    <= video_clk_in;
      de_idle   <= (de_in != de_q) ? 0 : de_idle + 1;
      vclk_idle <= (video_clk_in != vclk_q) ? 0 : vclk_idle + 1;
    end
  end
  // Data enable edge seen while outputs are up, then six steady awake cycles
  sequence s_de_edge;
    de_out_oe && chip_sleep_n && $changed(de_in);
  endsequence
  sequence s_awake_hold;
    (de_out_oe && chip_sleep_n && output_float_n) [*6];
  endsequence
  a_flag_rise: assert property (s_de_edge ##1 s_awake_hold |-> sync_activity_flag)
    else $error("flag low while data enable toggles");
  a_flag_fall: assert property (de_idle > de_timeout + 8 |-> !sync_activity_flag)
    else $error("flag high after data enable went quiet");
  a_pin_float: assert property (!output_float_n [*5] |-> !de_out_oe && pixel_out_oe == '0)
    else $error("outputs driven while float pin low");
  a_sleep_float: assert property (!chip_sleep_n [*5] |-> !de_out_oe && !sync_activity_flag)
    else $error("outputs or flag up while asleep");
  a_clk_loss: assert property (vclk_idle > 24 |-> !de_out_oe && !sync_activity_flag)
    else $error("outputs up without video clock");
  a_oe_group: assert property (pixel_out_oe == {data_w{de_out_oe}} && pixel_out_clock_oe == de_out_oe
    && general_control_out_2_oe == de_out_oe && general_control_out_3_oe == de_out_oe)
    else $error("floated outputs disagree");
  a_pull_low: assert property ((pixel_out & ~pixel_out_oe) == '0 && (de_out_oe || !de_out))
    else $error("floated output not low");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("access phase without ready");
endmodule

bind output_power_sync_detect output_power_sync_detect_chk #(
  .data_w(data_w),
  .de_timeout(de_timeout)
) chk_i (.*);

/* File: test/panel_model.sv */
// Panel-side view of the receiver pins with their weak pull-downs
module panel_model #(
  parameter int data_w = 24
) (
  input  wire logic [data_w-1:0] pix,
  input  wire logic [data_w-1:0] pix_oe,
  input  wire logic              de,
  input  wire logic              de_oe,
  output logic      [data_w-1:0] pix_pin,
  output logic                   de_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released pin reads ground, never its last value
  assign pix_pin = pix & pix_oe;
  assign de_pin  = de_oe ? de : 1'b0;
endmodule

/* File: test/output_power_sync_detect_bench.sv */
// Self-checking bench for the output power and sync-detect block
module output_power_sync_detect_bench
  import power_sync_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int          dw     = 24;
  localparam int          tmo    = 20;
  localparam logic [7:0]  ra [4] = '{ctrl_off, mask_off, tout_off, 8'h14};
  localparam logic [31:0] rx [4] = '{32'h0, 32'h0, 32'(tmo), 32'h0};
  logic               core_clk, nrst, chip_sleep_n, output_float_n, video_clk_in, de_in, pixel_clk_in;
  logic               general_control_out_1_in, general_control_out_2_in, general_control_out_3_in, psel, penable, pwrite, pready, pslverr, irq, err;
  logic               sync_activity_flag, general_control_out_1, pixel_out_clock, pixel_out_clock_oe;
  logic               de_out, de_out_oe, general_control_out_2, general_control_out_2_oe;
  logic               general_control_out_3, general_control_out_3_oe, de_pin, vclk_on, de_run;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [dw-1:0]      pixel_in, pixel_out, pixel_out_oe, pix_pin;
  logic [2:0][dw-1:0] ph;
  logic [2:0]         c1h;
  int                 miscompares, cmp_count;

  output_power_sync_detect #(.data_w(dw), .de_timeout(tmo)) dut (.*);
  panel_model #(.data_w(dw)) panel (.pix(pixel_out), .pix_oe(pixel_out_oe), .de(de_out), .de_oe(de_out_oe),
    .pix_pin(pix_pin), .de_pin(de_pin));

  // Core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Random video traffic and a three-deep history of what was sent
  always @(posedge core_clk) begin
    if (vclk_on) begin
      video_clk_in <= ~video_clk_in;
      pixel_clk_in <= ~pixel_clk_in;
    end
    if (de_run && $urandom_range(3) != 0) begin
      de_in <= ~de_in;
    end
    pixel_in <= dw'($urandom);
    {general_control_out_3_in, general_control_out_2_in, general_control_out_1_in} <= 3'($urandom);
    ph <= {ph[1:0], pixel_in};
    c1h <= {c1h[1:0], general_control_out_1_in};
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // One bus transfer; read data and error land in rd and err
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // Look at ready, data and error while settled, then finish on the next rising edge
    @(negedge core_clk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    rd  = prdata;
    err = pslverr;
    @(posedge core_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      miscompares++;
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    end_of_test();
  end

  // Main sequence
  initial begin
    void'($urandom(64));
    {nrst, psel, penable, pwrite, de_in, video_clk_in, pixel_clk_in, general_control_out_1_in, general_control_out_2_in, general_control_out_3_in} = '0;
    {paddr, pwdata, pixel_in, ph, c1h} = '0;
    {chip_sleep_n, output_float_n, vclk_on, de_run} = 4'hf;
    miscompares = 0;
    cmp_count = 0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, ra[k], 32'h0);
      chk(rd, rx[k]);
      chk({31'h0, err}, {31'h0, k == 3});
    end
    wt(30);
    chk(sync_activity_flag, 1'b1);
    for (int k = 0; k < 8; k++) begin
      wt(0);
      chk({general_control_out_1, pix_pin}, {c1h[2], ph[2]});
    end
    @(posedge core_clk);
    output_float_n <= 1'b0;
    wt(6);
    chk({7'h0, de_pin, pix_pin}, 32'h0);
    chk({7'h0, de_out_oe, pixel_out_oe}, 32'h0);
    chk({sync_activity_flag, general_control_out_1}, {1'b1, c1h[2]});
    @(posedge core_clk);
    output_float_n <= 1'b1;
    wt(6);
    chk({pixel_out_clock_oe, de_out_oe}, 2'h3);
    apb(1'b1, mask_off, 32'h1 << irq_fall_bit);
    apb(1'b1, irq_off, 32'hf);
    @(posedge core_clk);
    de_run <= 1'b0;
    wt(tmo + 12);
    chk({sync_activity_flag, irq}, 2'h1);
    apb(1'b1, irq_off, 32'h1 << irq_fall_bit);
    wt(2);
    chk(irq, 1'b0);
    @(posedge core_clk);
    de_run <= 1'b1;
    wt(12);
    chk({sync_activity_flag, irq}, 2'h2);
    apb(1'b0, irq_off, 32'h0);
    chk(rd & 32'h3, 32'h1);
    @(posedge core_clk);
    chip_sleep_n <= 1'b0;
    wt(6);
    chk({sync_activity_flag, general_control_out_1, de_pin, de_out_oe}, 4'h0);
    @(posedge core_clk);
    chip_sleep_n <= 1'b1;
    vclk_on <= 1'b0;
    wt(30);
    chk({sync_activity_flag, de_out_oe, pixel_out_clock_oe}, 3'h0);
    @(posedge core_clk);
    vclk_on <= 1'b1;
    wt(30);
    chk({sync_activity_flag, de_out_oe}, 2'h3);
    @(posedge core_clk);
    de_run <= 1'b0;
    wt(8);
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, ctrl_off, 32'h1 << b);
      apb(1'b0, ctrl_off, 32'h0);
      chk(rd, 32'h1 << b);
      wt(4);
      chk(de_out_oe, 1'b0);
      apb(1'b1, ctrl_off, 32'h0);
    end
    wt(10);
    end_of_test();
  end
endmodule
